// File: design/crtro_pkg.sv
// Notes on behaviour
// - One clock; 3.41 MHz scan rate from enable.
// - Counters: 8 columns, 8 rows, 40 characters, 16 lines (3 with CTRL_L16 clear).
// - Over three lines disables the spectrum display.
// - Off-timer gives beam to spectrum 140 us.
// - Draw-active sets after off-timer expiry, or at once with spectrum off.
// - Row 0 column 0 ends draw, retriggers timer.
// - Unblanked draw-active switches deflection to readout.
// - Off period jitters pseudorandomly to move gaps.
// - Cell top row and first three columns blank.
// - Counters step only when active and advancing, or on a skip.
// - Skip flag steps line counter, repeats until clear.
// - Counters drive deflection, row by row scan.
// - Glyph store holds 64 bits per 64 glyphs.
// - Each dot shift moves out one bit.
// - Row-advance strobe presents next glyph row.
// - Row-load strobe latches row into shift register.
// - Row-counter clear restarts glyph at first row.
// - Load at column 2, advance at column 4.
// - Written dot holds counters, unblanked, for 2 scan ticks; they step on the third.
package crtro_pkg;
  localparam int unsigned CLK_HZ        = 20000000;
  localparam int unsigned SCAN_HZ       = 3410000;
  localparam int unsigned OFF_TIME_US   = 140;
  localparam int unsigned OFF_CYCLES    = (OFF_TIME_US * (CLK_HZ / 1000000));
  localparam logic [11:0] OFF_CNT       = 12'(OFF_CYCLES);
  // Phase accumulator for the scan enable, in units of 10 kHz
  localparam logic [11:0] ACC_STEP      = 12'(SCAN_HZ / 10000);
  localparam logic [11:0] ACC_MOD       = 12'(CLK_HZ / 10000);
  localparam logic [2:0]  COL_LAST      = 3'h7;
  localparam logic [2:0]  ROW_LAST      = 3'h7;
  localparam logic [5:0]  CHR_LAST      = 6'h27;
  localparam logic [3:0]  LINE_LAST_16  = 4'hF;
  localparam logic [3:0]  LINE_LAST_3   = 4'h2;
  localparam logic [2:0]  COL_LOAD      = 3'h2;
  localparam logic [2:0]  COL_ADV       = 3'h4;
  localparam logic [2:0]  COL_FIRST_VIS = 3'h3;
  localparam logic [1:0]  DOT_HOLD      = 2'h3;
  localparam logic [7:0]  LFSR_SEED     = 8'hA5;
  localparam int unsigned BIT_BLANK     = 7;
  localparam int unsigned BIT_SKIP      = 6;
  // Register map (byte addresses)
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_GADDR    = 8'h08;
  localparam logic [7:0]  ADDR_GDATA    = 8'h0C;
  localparam int unsigned CTRL_EN       = 0;
  localparam int unsigned CTRL_SPEC     = 1;
  localparam int unsigned CTRL_L16      = 2;
  localparam logic [2:0]  CTRL_RESET    = 3'h0;
  typedef enum logic [1:0] {ST_IDLE, ST_OFF, ST_DRAW} crtro_state_t;
endpackage : crtro_pkg

// File: design/crtro_char_scan.sv
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module crtro_char_scan
  import crtro_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Character RAM
  output logic [9:0]       char_addr_o,
  input  wire logic [7:0]  char_data_i,
  // Deflection and beam
  output logic [8:0]       defl_x_o,
  output logic [6:0]       defl_y_o,
  output logic             readout_deflect_o,
  output logic             spectrum_enable_o,
  output logic             beam_unblank_o,
  // Character generator strobes
  output logic             char_draw_active_o,
  output logic             scan_advance_o,
  output logic             dot_shift_o,
  output logic             row_advance_o,
  output logic             row_load_strobe_o,
  output logic             glyph_row_counter_clear_o
);

  crtro_state_t st_q, st_d;
  logic [2:0]  ctrl_q, ctrl_d;
  logic [8:0]  gaddr_q, gaddr_d;
  logic [7:0]  glyph_mem [0:511];
  logic [11:0] acc_q, acc_d;
  logic        tick_q, tick_d;
  logic [11:0] off_q, off_d;
  logic [7:0]  lfsr_q, lfsr_d;
  logic [2:0]  col_q, col_d, row_q, row_d;
  logic [5:0]  chr_q, chr_d;
  logic [3:0]  line_q, line_d;
  logic [5:0]  code_q, code_d;
  logic        blank_q, blank_d;
  logic [2:0]  grow_q, grow_d;
  logic [7:0]  sr_q, sr_d;
  logic [1:0]  hold_q, hold_d;
  logic        unbl_q, unbl_d;
  logic        dot_q, rowadv_q, load_q, clr_q;
  logic        dot_d, rowadv_d, load_d, clr_d;
  logic        wr_en, rd_en, mapped, spec_off, visible, dot_now, adv;
  logic [3:0]  line_last;
  logic [7:0]  row_bits;

  // APB decode; the slave always answers in the access phase
  assign wr_en   = psel_i & penable_i & pwrite_i;
  assign rd_en   = psel_i & penable_i & ~pwrite_i;
  assign mapped  = (paddr_i == ADDR_CTRL) || (paddr_i == ADDR_STATUS) ||
                   (paddr_i == ADDR_GADDR) || (paddr_i == ADDR_GDATA);
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped;

  // Read multiplexer
  always_comb begin
    prdata_o = 32'h0000_0000;
    if (rd_en) begin
      case (paddr_i)
        ADDR_CTRL:   prdata_o = {29'h0000_0000, ctrl_q};
        ADDR_STATUS: prdata_o = {13'h0000, line_q, chr_q, row_q, col_q,
                                 spec_off, unbl_q, (st_q == ST_DRAW)};
        ADDR_GADDR:  prdata_o = {23'h00_0000, gaddr_q};
        ADDR_GDATA:  prdata_o = {24'h00_0000, glyph_mem[gaddr_q]};
        default:     prdata_o = 32'h0000_0000;
      endcase
    end
  end

  // Control and glyph address registers
  always_comb begin
    ctrl_d  = ctrl_q;
    gaddr_d = gaddr_q;
    if (wr_en && paddr_i == ADDR_CTRL) ctrl_d = pwdata_i[2:0];
    if (wr_en && paddr_i == ADDR_GADDR) gaddr_d = pwdata_i[8:0];
    if (wr_en && paddr_i == ADDR_GDATA) gaddr_d = gaddr_q + 9'h001;
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ctrl_q  <= CTRL_RESET;
      gaddr_q <= 9'h000;
    end else begin
      ctrl_q  <= ctrl_d;
      gaddr_q <= gaddr_d;
    end
  end

  // Glyph store: 64 glyphs of eight 8-bit rows, loaded by software
  always_ff @(posedge clk_i) begin
    if (wr_en && paddr_i == ADDR_GDATA) begin
      glyph_mem[gaddr_q] <= pwdata_i[7:0];
    end
  end

  // Scan-rate enable from the system clock
  always_comb begin
    tick_d = 1'b0;
    if (acc_q + ACC_STEP >= ACC_MOD) begin
      acc_d  = acc_q + ACC_STEP - ACC_MOD;
      tick_d = 1'b1;
    end else begin
      acc_d  = acc_q + ACC_STEP;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      acc_q  <= 12'h000;
      tick_q <= 1'b0;
    end else begin
      acc_q  <= acc_d;
      tick_q <= tick_d;
    end
  end

  // Beam sharing and dot decoding
  assign spec_off  = ~ctrl_q[CTRL_SPEC] | ctrl_q[CTRL_L16];
  assign line_last = ctrl_q[CTRL_L16] ? LINE_LAST_16 : LINE_LAST_3;
  assign visible   = (row_q != 3'h0) && (col_q >= COL_FIRST_VIS);
  assign dot_now   = (st_q == ST_DRAW) & sr_q[7] & visible & ~blank_q;
  assign row_bits  = glyph_mem[{code_q, grow_q}];
  // Counters stand still while a written dot is held
  assign scan_advance_o = (hold_q == 2'h0) ? ~dot_now : (hold_q == 2'h1);
  assign adv = tick_q & (st_q == ST_DRAW) & scan_advance_o;

  // Sequencer, off-timer, scan counters and character generator
  always_comb begin
    st_d     = st_q;
    off_d    = off_q;
    lfsr_d   = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    col_d    = col_q;
    row_d    = row_q;
    chr_d    = chr_q;
    line_d   = line_q;
    code_d   = code_q;
    blank_d  = blank_q;
    grow_d   = grow_q;
    sr_d     = sr_q;
    hold_d   = hold_q;
    unbl_d   = unbl_q;
    dot_d    = 1'b0;
    rowadv_d = 1'b0;
    load_d   = 1'b0;
    clr_d    = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (ctrl_q[CTRL_EN]) begin
          st_d  = ST_OFF;
          off_d = OFF_CNT + {4'h0, lfsr_q & 8'h3F};
        end
      end
      ST_OFF: begin
        if (off_q != 12'h000 && !spec_off) begin
          off_d = off_q - 12'h001;
        end else if (char_data_i[BIT_SKIP]) begin
          // Skipped character steps the line counter and tries again
          chr_d  = 6'h00;
          line_d = (line_q >= line_last) ? 4'h0 : line_q + 4'h1;
        end else begin
          st_d    = ST_DRAW;
          code_d  = char_data_i[5:0];
          blank_d = char_data_i[BIT_BLANK];
          grow_d  = 3'h0;
          clr_d   = 1'b1;
        end
      end
      ST_DRAW: begin
        if (tick_q && hold_q == 2'h0 && dot_now) begin
          hold_d = DOT_HOLD - 2'h1;
          unbl_d = 1'b1;
        end else if (tick_q && hold_q != 2'h0) begin
          hold_d = hold_q - 2'h1;
        end
        if (adv) begin
          unbl_d = 1'b0;
          dot_d  = 1'b1;
          col_d  = col_q + 3'h1;
          if (col_q == COL_LOAD) begin
            sr_d   = row_bits;
            load_d = 1'b1;
          end else begin
            sr_d = {sr_q[6:0], 1'b0};
          end
          if (col_q == COL_ADV) begin
            grow_d   = grow_q + 3'h1;
            rowadv_d = 1'b1;
          end
          if (col_q == COL_LAST) begin
            row_d = row_q + 3'h1;
            if (row_q == ROW_LAST) begin
              // Row 0 column 0 reached: end the character
              st_d  = ST_OFF;
              off_d = OFF_CNT + {4'h0, lfsr_q & 8'h3F};
              if (chr_q == CHR_LAST) begin
                chr_d  = 6'h00;
                line_d = (line_q >= line_last) ? 4'h0 : line_q + 4'h1;
              end else begin
                chr_d = chr_q + 6'h01;
              end
            end
          end
        end
      end
      default: st_d = ST_IDLE;
    endcase
    if (!ctrl_q[CTRL_EN]) begin
      st_d   = ST_IDLE;
      hold_d = 2'h0;
      unbl_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st_q     <= ST_IDLE;
      off_q    <= OFF_CNT;
      lfsr_q   <= LFSR_SEED;
      col_q    <= 3'h0;
      row_q    <= 3'h0;
      chr_q    <= 6'h00;
      line_q   <= 4'h0;
      code_q   <= 6'h00;
      blank_q  <= 1'b0;
      grow_q   <= 3'h0;
      sr_q     <= 8'h00;
      hold_q   <= 2'h0;
      unbl_q   <= 1'b0;
      dot_q    <= 1'b0;
      rowadv_q <= 1'b0;
      load_q   <= 1'b0;
      clr_q    <= 1'b0;
    end else begin
      st_q     <= st_d;
      off_q    <= off_d;
      lfsr_q   <= lfsr_d;
      col_q    <= col_d;
      row_q    <= row_d;
      chr_q    <= chr_d;
      line_q   <= line_d;
      code_q   <= code_d;
      blank_q  <= blank_d;
      grow_q   <= grow_d;
      sr_q     <= sr_d;
      hold_q   <= hold_d;
      unbl_q   <= unbl_d;
      dot_q    <= dot_d;
      rowadv_q <= rowadv_d;
      load_q   <= load_d;
      clr_q    <= clr_d;
    end
  end

  // Outputs toward RAM, deflection converters and beam drive
  assign char_addr_o = {line_q, chr_q};
  assign defl_x_o    = {chr_q, col_q};
  assign defl_y_o    = {line_q, row_q};
  assign char_draw_active_o = (st_q == ST_DRAW);
  assign readout_deflect_o  = (st_q == ST_DRAW) & ~blank_q;
  assign spectrum_enable_o  = ~spec_off & ~readout_deflect_o;
  assign beam_unblank_o     = unbl_q;
  assign dot_shift_o        = dot_q;
  assign row_advance_o      = rowadv_q;
  assign row_load_strobe_o  = load_q;
  assign glyph_row_counter_clear_o = clr_q;

endmodule : crtro_char_scan
`default_nettype wire

// File: tb/crtro_char_scan_sva.sv
`timescale 1ns/100ps
`default_nettype none
module crtro_char_scan_sva
  import crtro_pkg::*;
(
  // Clock, reset and bus
  input wire logic       clk_i,
  input wire logic       resetn_i,
  input wire logic       psel_i,
  input wire logic       penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic       pslverr_o,
  // Scan outputs
  input wire logic [8:0] defl_x_o,
  input wire logic [6:0] defl_y_o,
  input wire logic       readout_deflect_o,
  input wire logic       beam_unblank_o,
  input wire logic       char_draw_active_o,
  input wire logic       scan_advance_o,
  input wire logic       dot_shift_o,
  input wire logic       row_advance_o,
  input wire logic       row_load_strobe_o,
  input wire logic       glyph_row_counter_clear_o
);
  // Everything runs on the one clock and sleeps through reset
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  err_decode_a: assert property (psel_i && penable_i && paddr_i > 8'h0C |-> pslverr_o)
    else $error("unmapped access not flagged");
  deflect_draw_a: assert property (readout_deflect_o |-> char_draw_active_o)
    else $error("readout deflection without draw");
  // Strobes are registered, so they stand in the cycle after the step out of their column
  load_col_a: assert property (row_load_strobe_o |-> $past(defl_x_o[2:0]) == COL_LOAD)
    else $error("row load off its column");
  adv_col_a: assert property (row_advance_o |-> $past(defl_x_o[2:0]) == COL_ADV)
    else $error("row advance off its column");
  row_hold_a: assert property ($changed(defl_y_o[2:0]) |-> $past(char_draw_active_o))
    else $error("row moved while not drawing");
  dot_hold_a: assert property ($rose(beam_unblank_o) |=> $stable(defl_x_o) [*8])
    else $error("beam moved during dot");
  halt_dot_a: assert property ($rose(beam_unblank_o) |-> !scan_advance_o)
    else $error("counters free while dot written");
  dot_cell_a: assert property ($rose(beam_unblank_o) |-> defl_y_o[2:0] != 3'h0 &&
    defl_x_o[2:0] >= COL_FIRST_VIS)
    else $error("dot in blank margin");
  shift_once_a: assert property (dot_shift_o |=> !dot_shift_o)
    else $error("dot shift longer than a cycle");
  clear_start_a: assert property ($rose(char_draw_active_o) |->
    ##[0:2] glyph_row_counter_clear_o)
    else $error("no glyph row clear at draw start");
  // Main scenarios reached
  cover property ($rose(beam_unblank_o));
  cover property (row_load_strobe_o);
  cover property ($fell(char_draw_active_o));
endmodule : crtro_char_scan_sva
bind crtro_char_scan crtro_char_scan_sva u_sva (.clk_i, .resetn_i, .psel_i, .penable_i,
  .paddr_i, .pslverr_o, .defl_x_o, .defl_y_o, .readout_deflect_o, .beam_unblank_o,
  .char_draw_active_o, .scan_advance_o, .dot_shift_o, .row_advance_o, .row_load_strobe_o,
  .glyph_row_counter_clear_o);
`default_nettype wire

// File: tb/crtro_beam_model.sv
`timescale 1ns/100ps
`default_nettype none
module crtro_beam_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  // Character RAM side
  input  wire logic [9:0] char_addr_i,
  output logic      [7:0] char_data_o,
  // Beam side
  input  wire logic       beam_unblank_i,
  input  wire logic       readout_deflect_i,
  output int              dots_o
);
  logic lit_q;
  logic skip_line;
  // Middle lines of a 16-line page open with the skip code
  assign skip_line   = (char_addr_i[5:0] == 6'h00) && (char_addr_i[9:6] != 4'h0) &&
                       (char_addr_i[9:6] != 4'hF);
  // Code follows the character position, odd positions are spaces
  assign char_data_o = skip_line ? 8'h40 : {char_addr_i[0], 1'b0, char_addr_i[5:0]};
  // Z-axis drive tallies each dot lit under readout deflection
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      dots_o <= 0;
      lit_q  <= 1'b0;
    end else begin
      lit_q <= beam_unblank_i;
      if (beam_unblank_i && !lit_q && readout_deflect_i) dots_o <= dots_o + 1;
    end
  end
endmodule : crtro_beam_model
`default_nettype wire

// File: tb/crtro_char_scan_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module crtro_char_scan_tb_top;
  import crtro_pkg::*;
  logic        clk_i, resetn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
  logic [7:0]  paddr_i, char_data_i;
  logic [31:0] pwdata_i, prdata_o, rd, seed;
  logic [9:0]  char_addr_o;
  logic [8:0]  defl_x_o;
  logic [6:0]  defl_y_o;
  logic        readout_deflect_o, spectrum_enable_o, beam_unblank_o, char_draw_active_o;
  logic        scan_advance_o, dot_shift_o, row_advance_o, row_load_strobe_o;
  logic        glyph_row_counter_clear_o;
  logic [7:0]  glyph [8];
  int          errors, n_checks, cyc, dots, n_sh, n_ld, n_adv, n_dfl, n_up, t0, exp_dots;
  int          s [5];
  // Device and beam side
  crtro_char_scan DUT (.clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .char_addr_o, .char_data_i, .defl_x_o, .defl_y_o,
    .readout_deflect_o, .spectrum_enable_o, .beam_unblank_o, .char_draw_active_o,
    .scan_advance_o, .dot_shift_o, .row_advance_o, .row_load_strobe_o,
    .glyph_row_counter_clear_o);
  crtro_beam_model u_beam (.clk_i, .resetn_i, .char_addr_i(char_addr_o),
    .char_data_o(char_data_i), .beam_unblank_i(beam_unblank_o),
    .readout_deflect_i(readout_deflect_o), .dots_o(dots));
  // 50 ns clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Strobe tallies and the hang limit
  always @(posedge clk_i) begin
    cyc   <= cyc + 1;
    n_sh  <= n_sh + dot_shift_o;
    n_ld  <= n_ld + row_load_strobe_o;
    n_adv <= n_adv + row_advance_o;
    n_dfl <= n_dfl + readout_deflect_o;
    n_up  <= n_up + char_draw_active_o;
    if (cyc == 50000) begin
      errors++;
      final_report();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  // One APB transfer; data taken in the cycle whose closing edge sees pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // Access phase holds until a rising edge samples pready high
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd  = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic wait_draw(input logic v);
    while (char_draw_active_o !== v) @(posedge clk_i);
  endtask : wait_draw
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  initial begin
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, resetn_i} = '0;
    seed = 32'h7093A0C3;
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    // Reset values and an unmapped write
    apb(1'b0, ADDR_CTRL, 32'h0);
    check("ctrl", rd, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("status", rd, 32'h4);
    apb(1'b1, 8'h10, 32'hFFFFFFFF);
    check("unmapped", {31'h0, err}, 32'h1);
    // Clear the whole glyph store so every code reads as known empty rows
    for (int i = 0; i < 512; i++) apb(1'b1, ADDR_GDATA, 32'h0);
    // Random rows for glyph 0, then read back and count visible dots
    apb(1'b1, ADDR_GADDR, 32'h0);
    for (int r = 0; r < 8; r++) begin
      seed = xs(seed);
      glyph[r] = seed[7:0];
      apb(1'b1, ADDR_GDATA, {24'h0, glyph[r]});
    end
    apb(1'b0, ADDR_GADDR, 32'h0);
    check("gaddr", rd, 32'h8);
    exp_dots = 0;
    for (int r = 0; r < 8; r++) begin
      apb(1'b1, ADDR_GADDR, 32'(r));
      apb(1'b0, ADDR_GDATA, 32'h0);
      check("glyph", rd, {24'h0, glyph[r]});
      if (r > 0) for (int b = 3; b < 8; b++) exp_dots += glyph[r][b];
    end
    // Spectrum shared: full off time, then one drawn character
    apb(1'b1, ADDR_CTRL, 32'h3);
    t0 = cyc;
    @(negedge clk_i);
    check("spectrum", spectrum_enable_o, 32'h1);
    wait_draw(1'b1);
    check("off time", cyc - t0 >= OFF_CYCLES - 2 && cyc - t0 <= OFF_CYCLES + 70, 1);
    s = '{n_sh, n_ld, n_adv, dots, n_dfl};
    wait_draw(1'b0);
    t0 = cyc;
    repeat (3) @(posedge clk_i);
    check("shifts", n_sh - s[0], 64);
    check("loads", n_ld - s[1], 8);
    check("advances", n_adv - s[2], 8);
    check("dots", dots - s[3], exp_dots);
    // Next character is a space: timer retriggers, beam stays on spectrum
    s = '{n_sh, n_ld, n_adv, dots, n_dfl};
    wait_draw(1'b1);
    check("retrigger", cyc - t0 >= OFF_CYCLES - 2, 1);
    wait_draw(1'b0);
    repeat (3) @(posedge clk_i);
    check("blank dots", dots - s[3], 0);
    check("blank deflect", n_dfl - s[4], 0);
    // Readout off: nothing drawn however long we wait
    apb(1'b1, ADDR_CTRL, 32'h0);
    @(negedge clk_i);
    s[4] = n_up;
    repeat (3000) @(posedge clk_i);
    check("disabled", n_up - s[4], 0);
    // Spectrum off: characters follow with no off time
    apb(1'b1, ADDR_CTRL, 32'h5);
    @(negedge clk_i);
    check("spectrum off", spectrum_enable_o, 32'h0);
    wait_draw(1'b1);
    wait_draw(1'b0);
    t0 = cyc;
    wait_draw(1'b1);
    check("no off time", cyc - t0 <= 10, 1);
    // Middle lines open with a skip code: line 0 is followed straight by line 15
    while (defl_y_o[6:3] == 4'h0) @(posedge clk_i);
    wait_draw(1'b1);
    check("skip line", {28'h0, defl_y_o[6:3]}, 32'hF);
    final_report();
  end
endmodule : crtro_char_scan_tb_top
`default_nettype wire
